// >>> common/pll_corr_map.vh
// register offsets, field positions, reset values and counts of the stamp corrector
`ifndef PLL_CORR_MAP_VH
`define PLL_CORR_MAP_VH

// widths
`define STAMP_W 24
`define ADDR_W 8

// register byte offsets
`define OFF_CONTROL_ZERO 8'h00
`define OFF_CONTROL_ONE 8'h04
`define OFF_STATUS_WORD 8'h08
`define OFF_CORR_STATE 8'h0C
`define OFF_CORR_TRIG 8'h10
`define OFF_MEAS_STATE 8'h14
`define OFF_MEAS_TRIG 8'h18
`define OFF_INT_STATUS 8'h1C
`define OFF_INT_MASK 8'h20

// pll_control_zero fields
`define C0_MODE_BIT 0
`define C0_STATE_EN_BIT 1
`define C0_TRIG_EN_BIT 2
// pll_control_one fields
`define C1_EN_BIT 0
`define C1_FOUR_GAP_BIT 1

// pll_status_word fields
`define ST_LOCK_BIT 0
`define ST_BACK_BIT 1
`define ST_SHT_BIT 2
`define ST_SHS_BIT 3
`define ST_GAP_LSB 4

// interrupt status / mask fields
`define IRQ_MISSING_BIT 0
`define IRQ_SCORR_BIT 1
`define IRQ_TCORR_BIT 2
`define IRQ_LOCKLOST_BIT 3
`define IRQ_W 4

// reset values
`define CONTROL_ZERO_RST 3'h0
`define CONTROL_ONE_RST 2'h0
`define INT_MASK_RST 4'h0

// gap counts before the first lock flag returns
`define GAPS_NOMINAL 3'h2
`define GAPS_LEGACY 3'h4

`endif

// >>> design/stamp_corrector.v
// one stamp correction path: copy, or measured stamp plus/minus the correction value
module stamp_corrector #(
    parameter W = 24
) (
    // operands
    input wire [W-1:0] measured,
    input wire [W-1:0] increment,
    input wire [W-1:0] event_number,
    // selection
    input wire backward,
    input wire copy_only,
    // result
    output reg [W-1:0] corrected
);
    // correction value is increment count minus event number
    wire [W-1:0] corr_value;
    assign corr_value = increment - event_number;

    // pick copy, forward sum or backward difference
    always @* begin
        if (copy_only) begin
            corrected = measured;
        end else if (backward) begin
            corrected = measured - corr_value;
        end else begin
            corrected = measured + corr_value;
        end
    end
endmodule // stamp_corrector

// >>> design/pll_mode_correction.v
// stamp correction on reference mode switch, restart copy and first lock flag, apb slave
//
// The implementer's own choices: the APB slave port and the register addresses.
`include "pll_corr_map.vh"

module pll_mode_correction (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // events from input capture
    input wire trigger_event,
    input wire [`STAMP_W-1:0] trigger_stamp_in,
    input wire state_event,
    input wire [`STAMP_W-1:0] state_stamp_in,
    // pll core values
    input wire [`STAMP_W-1:0] increment_count_one,
    input wire [`STAMP_W-1:0] trigger_event_number,
    input wire [`STAMP_W-1:0] state_event_number,
    input wire direction_backward,
    input wire direction_change,
    input wire missing_state,
    input wire lock_achieved,
    // results
    output reg [`STAMP_W-1:0] corrected_state_stamp,
    output reg [`STAMP_W-1:0] corrected_trigger_stamp,
    output reg first_lock_flag,
    output reg irq
);
    // software control bits
    reg reference_mode_select_ff;
    reg state_input_enable_ff;
    reg trigger_input_enable_ff;
    reg pll_enable_bit_ff;
    reg four_gap_ff;
    reg [`IRQ_W-1:0] int_mask_ff;
    reg [`IRQ_W-1:0] int_status_ff;
    // mode shadows and restart markers
    reg shadow_trig_ff;
    reg shadow_state_ff;
    reg restart_trig_ff;
    reg restart_state_ff;
    reg enable_prev_ff;
    // measured stamps
    reg [`STAMP_W-1:0] measured_state_stamp_ff;
    reg [`STAMP_W-1:0] measured_trigger_stamp_ff;
    // lock recovery
    reg relock_pending_ff;
    reg [2:0] gap_count_ff;

    // bus decode helpers
    wire access;
    wire wr_en;
    wire [`STAMP_W-1:0] wr_stamp;
    wire [`IRQ_W-1:0] wr_irq;
    assign access = psel & penable & pready;
    // a write lands at the edge where pready is sampled high
    assign wr_en = access & pwrite;
    assign wr_stamp = pwdata[`STAMP_W-1:0];
    assign wr_irq = pwdata[`IRQ_W-1:0];

    // accepted events, only while running and input enabled
    wire trig_take;
    wire state_take;
    assign trig_take = trigger_event & pll_enable_bit_ff & trigger_input_enable_ff;
    assign state_take = state_event & pll_enable_bit_ff & state_input_enable_ff;

    // enable rise marks a restart; an event on that very edge must copy too
    wire enable_rise;
    assign enable_rise = pll_enable_bit_ff & ~enable_prev_ff;

    // switch detection against the shadows
    wire to_emergency;
    wire to_normal;
    assign to_emergency = state_take & ~shadow_state_ff & reference_mode_select_ff;
    assign to_normal = trig_take & shadow_trig_ff & ~reference_mode_select_ff;

    // corrected values from the shared path
    wire [`STAMP_W-1:0] state_result;
    wire [`STAMP_W-1:0] trig_result;

    // state side: normal to emergency
    stamp_corrector #(.W(`STAMP_W)) u_state_corr (
        .measured(state_stamp_in),
        .increment(increment_count_one),
        .event_number(state_event_number),
        .backward(direction_backward),
        .copy_only(restart_state_ff | enable_rise),
        .corrected(state_result)
    );

    // trigger side: emergency to normal
    stamp_corrector #(.W(`STAMP_W)) u_trig_corr (
        .measured(trigger_stamp_in),
        .increment(increment_count_one),
        .event_number(trigger_event_number),
        .backward(direction_backward),
        .copy_only(restart_trig_ff | enable_rise),
        .corrected(trig_result)
    );

    // register selects
    wire sel_c0;
    wire sel_c1;
    wire sel_cs;
    wire sel_ct;
    wire sel_is;
    wire sel_im;
    assign sel_c0 = (paddr == `OFF_CONTROL_ZERO);
    assign sel_c1 = (paddr == `OFF_CONTROL_ONE);
    assign sel_cs = (paddr == `OFF_CORR_STATE);
    assign sel_ct = (paddr == `OFF_CORR_TRIG);
    assign sel_is = (paddr == `OFF_INT_STATUS);
    assign sel_im = (paddr == `OFF_INT_MASK);

    // control registers written by software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_mode_select_ff <= 1'b0;
            state_input_enable_ff <= 1'b0;
            trigger_input_enable_ff <= 1'b0;
            pll_enable_bit_ff <= 1'b0;
            four_gap_ff <= 1'b0;
            int_mask_ff <= `INT_MASK_RST;
        end else if (wr_en) begin
            // restart order is kept by software
            if (sel_c0) begin
                reference_mode_select_ff <= pwdata[`C0_MODE_BIT];
                state_input_enable_ff <= pwdata[`C0_STATE_EN_BIT];
                trigger_input_enable_ff <= pwdata[`C0_TRIG_EN_BIT];
            end else if (sel_c1) begin
                pll_enable_bit_ff <= pwdata[`C1_EN_BIT];
                four_gap_ff <= pwdata[`C1_FOUR_GAP_BIT];
            end else if (sel_im) begin
                int_mask_ff <= wr_irq;
            end
        end
    end

    // mode shadows, captured only on accepted events
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_trig_ff <= 1'b0;
            shadow_state_ff <= 1'b0;
        end else begin
            // a stopped pll keeps its old shadows, so a restart sees the switch
            if (trig_take) begin
                shadow_trig_ff <= reference_mode_select_ff;
            end
            if (state_take) begin
                shadow_state_ff <= reference_mode_select_ff;
            end
        end
    end

    // restart markers: set when enable rises, cleared by that kind's next event
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_prev_ff <= 1'b0;
            restart_trig_ff <= 1'b0;
            restart_state_ff <= 1'b0;
        end else begin
            enable_prev_ff <= pll_enable_bit_ff;
            // an accepted event consumes its marker, even on the rising edge
            if (trig_take) begin
                restart_trig_ff <= 1'b0;
            end else if (enable_rise) begin
                restart_trig_ff <= 1'b1;
            end
            // state side keeps its own marker
            if (state_take) begin
                restart_state_ff <= 1'b0;
            end else if (enable_rise) begin
                restart_state_ff <= 1'b1;
            end
        end
    end

    // measured stamps follow every accepted event
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            measured_state_stamp_ff <= {`STAMP_W{1'b0}};
            measured_trigger_stamp_ff <= {`STAMP_W{1'b0}};
        end else begin
            // refused events leave the stamps as they are
            if (state_take) begin
                measured_state_stamp_ff <= state_stamp_in;
            end
            if (trig_take) begin
                measured_trigger_stamp_ff <= trigger_stamp_in;
            end
        end
    end

    // corrected stamps: software write beats hardware result
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            corrected_state_stamp <= {`STAMP_W{1'b0}};
            corrected_trigger_stamp <= {`STAMP_W{1'b0}};
        end else begin
            // state stamp
            if (wr_en & sel_cs) begin
                corrected_state_stamp <= wr_stamp;
            end else if (to_emergency) begin
                corrected_state_stamp <= state_result;
            end
            // trigger stamp
            if (wr_en & sel_ct) begin
                corrected_trigger_stamp <= wr_stamp;
            end else if (to_normal) begin
                corrected_trigger_stamp <= trig_result;
            end
        end
    end

    // gap target chosen by software, two by default
    wire [2:0] gap_target;
    assign gap_target = four_gap_ff ? `GAPS_LEGACY : `GAPS_NOMINAL;
    // direction change outside emergency mode leaves the flag alone
    wire lock_clear;
    assign lock_clear = direction_change & reference_mode_select_ff;
    wire gap_done;
    assign gap_done = relock_pending_ff & missing_state & (gap_count_ff + 3'h1 == gap_target);

    // first lock flag and gap counting
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_lock_flag <= 1'b0;
            relock_pending_ff <= 1'b0;
            gap_count_ff <= 3'h0;
        end else if (lock_clear) begin
            // newest direction change restarts recovery
            first_lock_flag <= 1'b0;
            relock_pending_ff <= 1'b1;
            gap_count_ff <= 3'h0;
        end else if (gap_done) begin
            // last gap of the chosen count restores the flag
            first_lock_flag <= 1'b1;
            relock_pending_ff <= 1'b0;
            gap_count_ff <= 3'h0;
        end else if (relock_pending_ff & missing_state) begin
            // gaps only count while recovering
            gap_count_ff <= gap_count_ff + 3'h1;
        end else if (lock_achieved & ~relock_pending_ff) begin
            // ordinary lock report, held off during recovery
            first_lock_flag <= 1'b1;
        end
    end

    // interrupt events
    wire [`IRQ_W-1:0] irq_events;
    assign irq_events[`IRQ_MISSING_BIT] = missing_state;
    assign irq_events[`IRQ_SCORR_BIT] = to_emergency;
    assign irq_events[`IRQ_TCORR_BIT] = to_normal;
    assign irq_events[`IRQ_LOCKLOST_BIT] = lock_clear & first_lock_flag;
    wire [`IRQ_W-1:0] irq_clear;
    assign irq_clear = (wr_en & sel_is) ? wr_irq : {`IRQ_W{1'b0}};
    wire [`IRQ_W-1:0] nxt_int_status;
    assign nxt_int_status = (int_status_ff & ~irq_clear) | irq_events;

    // sticky status, set wins over write-one clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_ff <= {`IRQ_W{1'b0}};
            irq <= 1'b0;
        end else begin
            int_status_ff <= nxt_int_status;
            // a mask write counts from the next edge
            irq <= |(nxt_int_status & int_mask_ff);
        end
    end

    // read mux
    reg [31:0] rd_word;
    reg rd_bad;
    always @* begin
        rd_word = 32'h00000000;
        rd_bad = 1'b0;
        if (paddr == `OFF_CONTROL_ZERO) begin
            rd_word[`C0_MODE_BIT] = reference_mode_select_ff;
            rd_word[`C0_STATE_EN_BIT] = state_input_enable_ff;
            rd_word[`C0_TRIG_EN_BIT] = trigger_input_enable_ff;
        end else if (paddr == `OFF_CONTROL_ONE) begin
            rd_word[`C1_EN_BIT] = pll_enable_bit_ff;
            rd_word[`C1_FOUR_GAP_BIT] = four_gap_ff;
        end else if (paddr == `OFF_STATUS_WORD) begin
            rd_word[`ST_LOCK_BIT] = first_lock_flag;
            rd_word[`ST_BACK_BIT] = direction_backward;
            rd_word[`ST_SHT_BIT] = shadow_trig_ff;
            rd_word[`ST_SHS_BIT] = shadow_state_ff;
            rd_word[`ST_GAP_LSB+2:`ST_GAP_LSB] = gap_count_ff;
        end else if (paddr == `OFF_CORR_STATE) begin
            rd_word[`STAMP_W-1:0] = corrected_state_stamp;
        end else if (paddr == `OFF_CORR_TRIG) begin
            rd_word[`STAMP_W-1:0] = corrected_trigger_stamp;
        end else if (paddr == `OFF_MEAS_STATE) begin
            rd_word[`STAMP_W-1:0] = measured_state_stamp_ff;
        end else if (paddr == `OFF_MEAS_TRIG) begin
            rd_word[`STAMP_W-1:0] = measured_trigger_stamp_ff;
        end else if (paddr == `OFF_INT_STATUS) begin
            rd_word[`IRQ_W-1:0] = int_status_ff;
        end else if (paddr == `OFF_INT_MASK) begin
            rd_word[`IRQ_W-1:0] = int_mask_ff;
        end else begin
            // unmapped address reads zero and flags an error
            rd_bad = 1'b1;
        end
    end

    // apb answer: one wait state, data and error registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h00000000 : rd_word;
            pslverr <= rd_bad;
        end else begin
            // answer stands one cycle only
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // pll_mode_correction

// >>> bench/pll_corr_props.sv
// port-level checks of the stamp corrector
`include "pll_corr_map.vh"
module pll_corr_props (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    // events and core values
    input wire trigger_event,
    input wire [`STAMP_W-1:0] trigger_stamp_in,
    input wire state_event,
    input wire [`STAMP_W-1:0] state_stamp_in,
    input wire [`STAMP_W-1:0] increment_count_one,
    input wire [`STAMP_W-1:0] trigger_event_number,
    input wire [`STAMP_W-1:0] state_event_number,
    input wire direction_backward,
    input wire direction_change,
    input wire missing_state,
    // results
    input wire [`STAMP_W-1:0] corrected_state_stamp,
    input wire [`STAMP_W-1:0] corrected_trigger_stamp,
    input wire first_lock_flag,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // accepted writes
    wire acc = psel && penable && pready && pwrite;
    wire wr_cs = acc && (paddr == `OFF_CORR_STATE);
    wire wr_ct = acc && (paddr == `OFF_CORR_TRIG);
    // corrected values, sign from detector direction
    wire [`STAMP_W-1:0] d_s = increment_count_one - state_event_number;
    wire [`STAMP_W-1:0] d_t = increment_count_one - trigger_event_number;
    wire [`STAMP_W-1:0] e_s = direction_backward ? state_stamp_in - d_s : state_stamp_in + d_s;
    wire [`STAMP_W-1:0] e_t = direction_backward ? trigger_stamp_in - d_t : trigger_stamp_in + d_t;
    // control mirrors and gap recovery tracking
    reg mode_ff, four_ff, mask_ff, rec_ff;
    reg [2:0] gaps_ff;
    wire [2:0] need = four_ff ? `GAPS_LEGACY : `GAPS_NOMINAL;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mode_ff, four_ff, mask_ff, rec_ff} <= 4'h0;
            gaps_ff <= 3'h0;
        end else begin
            if (acc && paddr == `OFF_CONTROL_ZERO) mode_ff <= pwdata[`C0_MODE_BIT];
            if (acc && paddr == `OFF_CONTROL_ONE) four_ff <= pwdata[`C1_FOUR_GAP_BIT];
            if (acc && paddr == `OFF_INT_MASK) mask_ff <= pwdata[`IRQ_MISSING_BIT];
            if (direction_change && mode_ff) begin
                rec_ff <= 1'b1;
                gaps_ff <= 3'h0;
            end else if (rec_ff && missing_state) begin
                gaps_ff <= gaps_ff + 3'h1;
                rec_ff <= (gaps_ff + 3'h1 != need);
            end
        end
    end
    sequence s_wait_access;
        psel && penable && !pready;
    endsequence
    sequence s_last_gap;
        rec_ff && missing_state && !direction_change && gaps_ff == need - 3'h1;
    endsequence
    apb_one_wait_a: assert property (s_wait_access |=> pready) else $error("no answer after one wait");
    state_corr_a: assert property (state_event |=> $stable(corrected_state_stamp) || $past(wr_cs)
        || corrected_state_stamp == $past(e_s) || corrected_state_stamp == $past(state_stamp_in))
        else $error("bad state stamp");
    trig_corr_a: assert property (trigger_event |=> $stable(corrected_trigger_stamp) || $past(wr_ct)
        || corrected_trigger_stamp == $past(e_t) || corrected_trigger_stamp == $past(trigger_stamp_in))
        else $error("bad trigger stamp");
    state_quiet_a: assert property (!state_event && !wr_cs |=> $stable(corrected_state_stamp))
        else $error("state stamp moved");
    stamp_write_a: assert property (wr_cs && !state_event |=>
        corrected_state_stamp == $past(pwdata[`STAMP_W-1:0])) else $error("state stamp write lost");
    lock_clear_a: assert property (direction_change && mode_ff |=> !first_lock_flag)
        else $error("lock kept");
    lock_hold_a: assert property (rec_ff |-> !first_lock_flag) else $error("lock early");
    lock_return_a: assert property (s_last_gap |=> first_lock_flag) else $error("lock late");
    irq_gap_a: assert property (missing_state && mask_ff |=> irq) else $error("no gap irq");
endmodule // pll_corr_props

bind pll_mode_correction pll_corr_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .trigger_event(trigger_event),
    .trigger_stamp_in(trigger_stamp_in), .state_event(state_event), .state_stamp_in(state_stamp_in),
    .increment_count_one(increment_count_one), .trigger_event_number(trigger_event_number),
    .state_event_number(state_event_number), .direction_backward(direction_backward),
    .direction_change(direction_change), .missing_state(missing_state),
    .corrected_state_stamp(corrected_state_stamp), .corrected_trigger_stamp(corrected_trigger_stamp),
    .first_lock_flag(first_lock_flag), .irq(irq));

// >>> bench/capture_model.sv
// input capture model: one-cycle edge events with stamps
`include "pll_corr_map.vh"
module capture_model (
    // clock
    input wire pclk,
    // events
    output logic trigger_event,
    output logic [`STAMP_W-1:0] trigger_stamp_in,
    output logic state_event,
    output logic [`STAMP_W-1:0] state_stamp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle values
    initial begin
        {trigger_event, state_event} = 2'h0;
        trigger_stamp_in = 24'h5A5A5A;
        state_stamp_in = 24'hA5A5A5;
    end
    // one event; stamp valid only in its cycle, scrambled after
    task automatic fire(input logic st, input logic [`STAMP_W-1:0] v);
        @(posedge pclk);
        if (st) begin
            state_event <= 1'b1;
            state_stamp_in <= v;
        end else begin
            trigger_event <= 1'b1;
            trigger_stamp_in <= v;
        end
        @(posedge pclk);
        {state_event, trigger_event} <= 2'h0;
        state_stamp_in <= ~state_stamp_in;
        trigger_stamp_in <= ~trigger_stamp_in;
        @(posedge pclk);
    endtask
endmodule // capture_model

// >>> bench/tb_top.sv
// self-checking bench of the stamp corrector
`include "pll_corr_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // apb, core values and results
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, dc, gap, lk, dirb, trg, sev, lock, irq;
    logic [`ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [`STAMP_W-1:0] inc, nt, ns, tst, sst, cs, ct;
    int n_fail, check_count;
    capture_model cap (.pclk(pclk), .trigger_event(trg), .trigger_stamp_in(tst), .state_event(sev),
        .state_stamp_in(sst));
    pll_mode_correction DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger_event(trg), .trigger_stamp_in(tst), .state_event(sev), .state_stamp_in(sst),
        .increment_count_one(inc), .trigger_event_number(nt), .state_event_number(ns),
        .direction_backward(dirb), .direction_change(dc), .missing_state(gap), .lock_achieved(lk),
        .corrected_state_stamp(cs), .corrected_trigger_stamp(ct), .first_lock_flag(lock), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // core pulse: 0 direction change, 1 gap, 2 lock
    task automatic pulse(input int k);
        @(posedge pclk);
        dc <= (k == 0);
        gap <= (k == 1);
        lk <= (k == 2);
        @(posedge pclk);
        {dc, gap, lk} <= 3'h0;
        @(posedge pclk);
    endtask
    function automatic logic [`STAMP_W-1:0] corr(input logic [`STAMP_W-1:0] s, n, input logic b);
        corr = b ? s - (inc - n) : s + (inc - n);
    endfunction
    task automatic t_regs;
        rdc(`OFF_CONTROL_ZERO, 32'h0);
        rdc(`OFF_CONTROL_ONE, 32'h0);
        rdc(`OFF_INT_MASK, 32'h0);
        rdc(8'h24, 32'h0);
        chk(err, 1'b1);
        wr(8'hFC, 32'hFFFFFFFF);
        chk(err, 1'b1);
    endtask
    task automatic t_switch;
        logic [`STAMP_W-1:0] v;
        wr(`OFF_CONTROL_ZERO, 32'h6);
        wr(`OFF_CONTROL_ONE, 32'h1);
        cap.fire(1'b1, 24'h100000);
        cap.fire(1'b0, 24'h200000);
        wr(`OFF_CONTROL_ZERO, 32'h7);
        cap.fire(1'b1, 24'h123456);
        chk(cs, corr(24'h123456, ns, 1'b0));
        rdc(`OFF_STATUS_WORD, 32'h8);
        v = ct;
        cap.fire(1'b0, 24'h222222);
        chk(ct, v);
        dirb <= 1'b1;
        wr(`OFF_CONTROL_ZERO, 32'h6);
        cap.fire(1'b0, 24'h000050);
        chk(ct, corr(24'h000050, nt, 1'b1));
        v = cs;
        cap.fire(1'b1, 24'h333333);
        chk(cs, v);
    endtask
    task automatic t_restart;
        logic [`STAMP_W-1:0] v;
        wr(`OFF_CONTROL_ONE, 32'h0);
        wr(`OFF_CONTROL_ZERO, 32'h7);
        v = cs;
        cap.fire(1'b1, 24'h0ABCDE);
        chk(cs, v);
        wr(`OFF_CONTROL_ONE, 32'h1);
        cap.fire(1'b1, 24'h345678);
        chk(cs, 24'h345678);
        cap.fire(1'b0, 24'h444444);
        wr(`OFF_CONTROL_ONE, 32'h0);
        wr(`OFF_CONTROL_ZERO, 32'h6);
        wr(`OFF_CONTROL_ONE, 32'h1);
        cap.fire(1'b0, 24'h0F0F0F);
        chk(ct, 24'h0F0F0F);
    endtask
    task automatic t_write;
        wr(`OFF_CORR_STATE, 32'h00ABCDEF);
        rdc(`OFF_CORR_STATE, 32'h00ABCDEF);
        chk(cs, 24'hABCDEF);
        wr(`OFF_CORR_TRIG, 32'h00FEDCBA);
        rdc(`OFF_CORR_TRIG, 32'h00FEDCBA);
        wr(`OFF_MEAS_STATE, 32'h0);
        rdc(`OFF_MEAS_STATE, 32'h00345678);
        rdc(`OFF_MEAS_TRIG, 32'h000F0F0F);
    endtask
    task automatic t_irq;
        rdc(`OFF_INT_STATUS, 32'h6);
        wr(`OFF_INT_STATUS, 32'hF);
        pulse(1);
        chk(irq, 1'b0);
        rdc(`OFF_INT_STATUS, 32'h1);
        wr(`OFF_INT_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        wr(`OFF_INT_STATUS, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        wr(`OFF_INT_MASK, 32'h1);
    endtask
    task automatic t_lock(input logic four);
        int n;
        n = four ? 4 : 2;
        wr(`OFF_CONTROL_ZERO, 32'h7);
        wr(`OFF_CONTROL_ONE, {30'h0, four, 1'b1});
        pulse(2);
        chk(lock, 1'b1);
        pulse(0);
        chk(lock, 1'b0);
        for (int g = 1; g <= n; g++) begin
            pulse(1);
            chk(lock, g == n);
        end
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        #100000;
        n_fail++;
        tally_and_finish;
    end
    initial begin
        {presetn, psel, penable, pwrite, dc, gap, lk, dirb} = 8'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        inc = 24'h001000;
        nt = 24'h000100;
        ns = 24'h000300;
        n_fail = 0;
        check_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_switch;
        t_restart;
        t_write;
        t_irq;
        t_lock(1'b0);
        t_lock(1'b1);
        tally_and_finish;
    end
endmodule // tb_top
